// File: rtl/swr_pkg.sv
// Purpose: Shared constants, types and timing for the single-wire slot and ROM layer
// Assumes: core_clk at 25 MHz; times held in ns and turned into cycle counts here
// Notes:   Cycle counts for least times round up to whole cycles

package swr_pkg;

	// Clock period of core_clk in ns
	localparam int unsigned CLK_PERIOD_NS = 40;

	// Write sample point, standard and overdrive speed
	localparam int unsigned WR_SAMPLE_STD_NS = 30000;
	localparam int unsigned WR_SAMPLE_OD_NS  = 4000;
	// End of our own pulldown in a read slot; must stay below the sample point
	localparam int unsigned RD_HOLD_STD_NS   = 28000;
	localparam int unsigned RD_HOLD_OD_NS    = 3000;
	// Reset low time that returns the device to standard speed
	localparam int unsigned RESET_LONG_NS    = 480000;
	// Shortest low time that counts as a reset while in overdrive
	localparam int unsigned RESET_OD_NS      = 48000;
	// Presence pulse: wait after the rising edge, then low time
	localparam int unsigned PD_WAIT_STD_NS   = 15000;
	localparam int unsigned PD_LOW_STD_NS    = 60000;
	localparam int unsigned PD_WAIT_OD_NS    = 2000;
	localparam int unsigned PD_LOW_OD_NS     = 8000;

	// Derived cycle counts, rounded up
	localparam int unsigned WR_SAMPLE_STD_CYC = (WR_SAMPLE_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WR_SAMPLE_OD_CYC  = (WR_SAMPLE_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RD_HOLD_STD_CYC   = (RD_HOLD_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RD_HOLD_OD_CYC    = (RD_HOLD_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_LONG_CYC    = (RESET_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_OD_CYC      = (RESET_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PD_WAIT_STD_CYC   = (PD_WAIT_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PD_LOW_STD_CYC    = (PD_LOW_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PD_WAIT_OD_CYC    = (PD_WAIT_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PD_LOW_OD_CYC     = (PD_LOW_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Width of the slot timer and the low-time counter
	localparam int unsigned CNT_W = 14;

	// Identifier layout
	localparam int unsigned ID_BITS = 64;
	localparam int unsigned CMD_BITS = 8;

	// Identifier value; arbitrary, replaced per part
	localparam logic [63:0] ROM_ID_RESET = 64'h5a3c_1e2d_0f4b_6a28;

	// ROM command codes
	localparam logic [7:0] CMD_SEARCH   = 8'hf0;
	localparam logic [7:0] CMD_READ_ID  = 8'h33;
	localparam logic [7:0] CMD_MATCH    = 8'h55;
	localparam logic [7:0] CMD_SKIP     = 8'hcc;
	localparam logic [7:0] CMD_RESUME   = 8'ha5;
	localparam logic [7:0] CMD_OD_SKIP  = 8'h3c;
	localparam logic [7:0] CMD_OD_MATCH = 8'h69;

	// Slot engine states
	typedef enum logic [2:0] {
		EN_IDLE,
		EN_SLOT,
		EN_WAIT_HIGH,
		EN_PD_WAIT,
		EN_PD_LOW
	} swr_eng_e;

	// ROM layer states
	typedef enum logic [2:0] {
		RM_HALT,
		RM_CMD,
		RM_SEARCH,
		RM_READ,
		RM_MATCH,
		RM_FUNC
	} swr_rom_e;

	// One sampled bit from the slot engine
	typedef struct packed {
		logic strobe;
		logic value;
	} swr_slot_s;

endpackage

// File: rtl/swr_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH of at least 2
// Notes:   Flags are registered, so in_ready and out_valid come from flops

`timescale 1ns/10ps

module swr_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage words
	logic [PTR_W-1:0] wr_ptr;         // Next slot to fill
	logic [PTR_W-1:0] rd_ptr;         // Oldest word
	logic [CNT_W-1:0] count;          // Words held
	logic [CNT_W-1:0] next_count;     // Count after this cycle
	logic             push;           // Word taken in
	logic             pop;            // Word handed out

	// Handshakes only on honest flags
	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	// Occupancy after this cycle
	always_comb begin
		next_count = count;
		if (push & ~pop) begin
			next_count = count + CNT_W'(1);
		end else if (pop & ~push) begin
			next_count = count - CNT_W'(1);
		end
	end

	// Pointers, count and registered flags
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PTR_W'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PTR_W'(1);
			end
			count     <= next_count;
			in_ready  <= next_count != FULL_CNT;
			out_valid <= next_count != '0;
		end
	end

	// Data words carry no reset; only written slots are ever read
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule

// File: rtl/swr_slot_rom.sv
// Purpose: Peripheral side of a single-wire open-drain link: bit slots and ROM commands
// Assumes: dq_in synchronous to core_clk and already filtered; dq_out/dq_oe drive low only
// Notes:   Function-phase slots are taken as write bits and packed into bytes for the FIFO

`timescale 1ns/10ps

module swr_slot_rom #(
	parameter logic [63:0] ROM_ID         = swr_pkg::ROM_ID_RESET,
	parameter int unsigned RESET_LONG_CYC = swr_pkg::RESET_LONG_CYC,
	parameter int unsigned FIFO_DEPTH     = 4
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Open-drain data line
	input  wire logic       dq_in,
	output logic            dq_out,
	output logic            dq_oe,
	// Link status
	output logic            fn_active,
	output logic            overdrive_flag,
	output logic            resume_selected_flag,
	// Function-phase byte stream
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	input  wire logic       rx_ready
);

	localparam int unsigned W = swr_pkg::CNT_W;
	localparam logic [W-1:0] CNT_MAX = '1;
	localparam logic [5:0]   LAST_IDX = 6'(swr_pkg::ID_BITS - 1);
	localparam logic [2:0]   LAST_CMD = 3'(swr_pkg::CMD_BITS - 1);

	// Slot engine
	swr_pkg::swr_eng_e eng;            // Engine state
	logic [W-1:0]      t_cnt;          // Cycles since falling edge or phase start
	logic [W-1:0]      low_cnt;        // Cycles the line has been low
	logic              line_q;         // Line level one cycle back
	swr_pkg::swr_slot_s slot;          // Sampled bit, one-cycle strobe
	logic [W-1:0]      sample_cyc;     // Write sample point at current speed
	logic [W-1:0]      hold_cyc;       // End of read pulldown at current speed
	logic [W-1:0]      pd_wait_cyc;    // Presence wait at current speed
	logic [W-1:0]      pd_low_cyc;     // Presence low at current speed
	logic              fall;           // Line went low this cycle
	logic              rise;           // Line went high this cycle
	logic              long_reset;     // Low long enough for a full reset
	logic              bus_reset;      // A reset pulse just ended

	// ROM layer
	swr_pkg::swr_rom_e rom;            // ROM layer state
	logic [7:0]        cmd_sh;         // Command shift register
	logic [2:0]        cmd_cnt;        // Command bits received
	logic [5:0]        idx;            // Identifier bit position
	logic [1:0]        phase;          // Search triplet position
	logic              mismatch;       // Match saw a differing bit
	logic [7:0]        next_cmd;       // Command including the current bit
	logic              cmd_done;       // Last command bit taken
	logic              id_bit;         // Identifier bit at idx
	logic              drive_req;      // Next slot should return a zero
	logic              rc_set;         // Selection succeeded
	logic              rc_clear;       // Another command addressed the bus

	// Byte path toward the FIFO
	logic [7:0]        fn_sh;          // Function byte being built
	logic [2:0]        fn_cnt;         // Function bits received
	logic              byte_pend;      // Completed byte waiting for the FIFO
	logic [7:0]        byte_reg;       // Completed byte
	logic              fifo_ready;     // FIFO can take a byte

	// The pin only ever pulls low
	assign dq_out = 1'b0;

	// Speed-dependent timing
	assign sample_cyc  = overdrive_flag ? W'(swr_pkg::WR_SAMPLE_OD_CYC) : W'(swr_pkg::WR_SAMPLE_STD_CYC);
	assign hold_cyc    = overdrive_flag ? W'(swr_pkg::RD_HOLD_OD_CYC) : W'(swr_pkg::RD_HOLD_STD_CYC);
	assign pd_wait_cyc = overdrive_flag ? W'(swr_pkg::PD_WAIT_OD_CYC) : W'(swr_pkg::PD_WAIT_STD_CYC);
	assign pd_low_cyc  = overdrive_flag ? W'(swr_pkg::PD_LOW_OD_CYC) : W'(swr_pkg::PD_LOW_STD_CYC);

	// Edges and reset recognition
	assign fall       = line_q & ~dq_in;
	assign rise       = ~line_q & dq_in;
	assign long_reset = low_cnt >= W'(RESET_LONG_CYC);
	// In overdrive a short reset also counts; speed between the two bounds is kept
	assign bus_reset  = rise & (long_reset | (overdrive_flag & (low_cnt >= W'(swr_pkg::RESET_OD_CYC))));

	// Line history and low-time counter, saturating
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			line_q  <= 1'b1;
			low_cnt <= '0;
		end else begin
			line_q <= dq_in;
			if (dq_in) begin
				low_cnt <= '0;
			end else if (low_cnt != CNT_MAX) begin
				low_cnt <= low_cnt + W'(1);
			end
		end
	end

	// Slot engine: timer started on each falling edge, presence after a reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			eng   <= swr_pkg::EN_IDLE;
			t_cnt <= '0;
			dq_oe <= 1'b0;
		end else if (bus_reset) begin
			// End of a reset pulse wins over any slot in flight
			eng   <= swr_pkg::EN_PD_WAIT;
			t_cnt <= '0;
			dq_oe <= 1'b0;
		end else begin
			case (eng)
				swr_pkg::EN_IDLE: begin
					if (fall) begin
						// Timer starts at the controller's edge; zero reply drives at once
						eng   <= swr_pkg::EN_SLOT;
						t_cnt <= W'(1);
						dq_oe <= drive_req;
					end
				end
				swr_pkg::EN_SLOT: begin
					t_cnt <= t_cnt + W'(1);
					if (t_cnt == hold_cyc) begin
						dq_oe <= 1'b0;
					end
					if (t_cnt == sample_cyc) begin
						eng <= swr_pkg::EN_WAIT_HIGH;
					end
				end
				swr_pkg::EN_WAIT_HIGH: begin
					// Recovery is the controller's; we only wait for the line to return
					if (dq_in) begin
						eng <= swr_pkg::EN_IDLE;
					end
				end
				swr_pkg::EN_PD_WAIT: begin
					t_cnt <= t_cnt + W'(1);
					if (t_cnt == pd_wait_cyc) begin
						eng   <= swr_pkg::EN_PD_LOW;
						t_cnt <= '0;
						dq_oe <= 1'b1;
					end
				end
				swr_pkg::EN_PD_LOW: begin
					t_cnt <= t_cnt + W'(1);
					if (t_cnt == pd_low_cyc) begin
						// Our own low must not look like a slot
						eng   <= swr_pkg::EN_WAIT_HIGH;
						dq_oe <= 1'b0;
					end
				end
				default: begin
					eng   <= swr_pkg::EN_IDLE;
					dq_oe <= 1'b0;
				end
			endcase
		end
	end

	// One sampled bit per slot, taken at the single fixed point
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slot <= '0;
		end else begin
			slot.strobe <= (eng == swr_pkg::EN_SLOT) && (t_cnt == sample_cyc) && !bus_reset;
			slot.value  <= dq_in;
		end
	end

	// ROM layer helpers
	assign id_bit   = ROM_ID[idx];
	assign next_cmd = {slot.value, cmd_sh[7:1]};
	assign cmd_done = slot.strobe && (rom == swr_pkg::RM_CMD) && (cmd_cnt == LAST_CMD);

	// Reply for the coming slot; a one reply never drives
	always_comb begin
		drive_req = 1'b0;
		case (rom)
			swr_pkg::RM_SEARCH: begin
				if (phase == 2'd0) begin
					drive_req = ~id_bit;
				end else if (phase == 2'd1) begin
					drive_req = id_bit;
				end
			end
			swr_pkg::RM_READ: begin
				drive_req = ~id_bit;
			end
			default: begin
				drive_req = 1'b0;
			end
		endcase
	end

	// ROM command decode and identifier sequencing
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rom       <= swr_pkg::RM_HALT;
			cmd_sh    <= '0;
			cmd_cnt   <= '0;
			idx       <= '0;
			phase     <= '0;
			mismatch  <= 1'b0;
			fn_active <= 1'b0;
		end else if (bus_reset) begin
			// Every reset pulse starts a fresh command; this also wakes a halted device
			rom       <= swr_pkg::RM_CMD;
			cmd_cnt   <= '0;
			idx       <= '0;
			phase     <= '0;
			mismatch  <= 1'b0;
			fn_active <= 1'b0;
		end else if (slot.strobe) begin
			case (rom)
				swr_pkg::RM_CMD: begin
					cmd_sh  <= next_cmd;
					cmd_cnt <= cmd_cnt + 3'd1;
					if (cmd_done) begin
						case (next_cmd)
							swr_pkg::CMD_SEARCH: rom <= swr_pkg::RM_SEARCH;
							swr_pkg::CMD_READ_ID: rom <= swr_pkg::RM_READ;
							swr_pkg::CMD_MATCH: rom <= swr_pkg::RM_MATCH;
							swr_pkg::CMD_OD_MATCH: rom <= swr_pkg::RM_MATCH;
							swr_pkg::CMD_SKIP: begin
								rom       <= swr_pkg::RM_FUNC;
								fn_active <= 1'b1;
							end
							swr_pkg::CMD_OD_SKIP: begin
								rom       <= swr_pkg::RM_FUNC;
								fn_active <= 1'b1;
							end
							swr_pkg::CMD_RESUME: begin
								rom       <= resume_selected_flag ? swr_pkg::RM_FUNC : swr_pkg::RM_HALT;
								fn_active <= resume_selected_flag;
							end
							default: rom <= swr_pkg::RM_HALT;
						endcase
					end
				end
				swr_pkg::RM_SEARCH: begin
					if (phase != 2'd2) begin
						phase <= phase + 2'd1;
					end else if (slot.value != id_bit) begin
						rom <= swr_pkg::RM_HALT;
					end else if (idx == LAST_IDX) begin
						rom       <= swr_pkg::RM_FUNC;
						fn_active <= 1'b1;
					end else begin
						idx   <= idx + 6'd1;
						phase <= 2'd0;
					end
				end
				swr_pkg::RM_READ: begin
					if (idx == LAST_IDX) begin
						rom       <= swr_pkg::RM_FUNC;
						fn_active <= 1'b1;
					end else begin
						idx <= idx + 6'd1;
					end
				end
				swr_pkg::RM_MATCH: begin
					// Each device decides alone, so the bus population does not matter
					if (idx == LAST_IDX) begin
						if (mismatch || (slot.value != id_bit)) begin
							rom <= swr_pkg::RM_HALT;
						end else begin
							rom       <= swr_pkg::RM_FUNC;
							fn_active <= 1'b1;
						end
					end else begin
						mismatch <= mismatch | (slot.value != id_bit);
						idx      <= idx + 6'd1;
					end
				end
				default: begin
					rom <= rom;
				end
			endcase
		end
	end

	// Speed flag: set by the two overdrive commands, cleared only by a long reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			overdrive_flag <= 1'b0;
		end else if (bus_reset && long_reset) begin
			overdrive_flag <= 1'b0;
		end else if (cmd_done && (next_cmd == swr_pkg::CMD_OD_SKIP || next_cmd == swr_pkg::CMD_OD_MATCH)) begin
			overdrive_flag <= 1'b1;
		end
	end

	// Selection success and foreign access
	assign rc_set = slot.strobe && !bus_reset && (idx == LAST_IDX) && (
		((rom == swr_pkg::RM_MATCH) && !mismatch && (slot.value == id_bit)) ||
		((rom == swr_pkg::RM_SEARCH) && (phase == 2'd2) && (slot.value == id_bit)));
	assign rc_clear = cmd_done && (next_cmd != swr_pkg::CMD_RESUME);

	// Resume flag; a success wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			resume_selected_flag <= 1'b0;
		end else if (rc_set) begin
			resume_selected_flag <= 1'b1;
		end else if (rc_clear) begin
			resume_selected_flag <= 1'b0;
		end
	end

	// Function bytes; new bits are ignored while a byte waits for room
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fn_sh     <= '0;
			fn_cnt    <= '0;
			byte_pend <= 1'b0;
			byte_reg  <= '0;
		end else begin
			if (byte_pend && fifo_ready) begin
				byte_pend <= 1'b0;
			end
			if (bus_reset) begin
				fn_cnt <= '0;
			end else if (slot.strobe && (rom == swr_pkg::RM_FUNC) && !byte_pend) begin
				fn_sh  <= {slot.value, fn_sh[7:1]};
				fn_cnt <= fn_cnt + 3'd1;
				if (fn_cnt == 3'd7) begin
					byte_pend <= 1'b1;
					byte_reg  <= {slot.value, fn_sh[7:1]};
				end
			end
		end
	end

	// Byte buffer toward the user side
	swr_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.in_valid  (byte_pend),
		.in_data   (byte_reg),
		.in_ready  (fifo_ready),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);

endmodule

// File: verification/swr_slot_rom_props.sv
// Purpose: Port-level checks for the single-wire slot and ROM layer
// Assumes: One clock domain; figures in core_clk cycles of 40 ns
// Notes:   Pulldown lengths carry one or two cycles of slack either way
`timescale 1ns/10ps
module swr_slot_rom_props #(
	parameter logic [63:0] ROM_ID         = 64'h0000_0000_0000_0000,
	parameter int unsigned RESET_LONG_CYC = 12000,
	parameter int unsigned FIFO_DEPTH     = 4
) (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       resetn,
	// Line and status
	input wire logic       dq_in,
	input wire logic       dq_out,
	input wire logic       dq_oe,
	input wire logic       fn_active,
	input wire logic       overdrive_flag,
	input wire logic       resume_selected_flag,
	// Byte stream
	input wire logic       rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic       rx_ready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic [15:0] oe_cnt;  // Length of our pulldown so far
	logic [15:0] low_cnt; // Length of the last low period
	logic        prev_in; // Line one cycle back
	// Pulldown length counter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			oe_cnt <= 16'h0000;
		end else begin
			oe_cnt <= dq_oe ? oe_cnt + 16'h0001 : 16'h0000;
		end
	end
	// Low period length; held while high so a late flag change still sees it
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prev_in <= 1'b1;
			low_cnt <= 16'h0000;
		end else begin
			prev_in <= dq_in;
			if (!dq_in) begin
				low_cnt <= prev_in ? 16'h0001 : low_cnt + 16'(low_cnt != 16'hffff);
			end
		end
	end
	property p_oe_at_fall;
		$rose(dq_oe) && !$past(dq_in) |-> $past(dq_in, 2);
	endproperty
	a_oe_at_fall: assert property (p_oe_at_fall) else $error("pulldown not tied to a fall");
	property p_oe_len;
		$fell(dq_oe) |-> (overdrive_flag ? oe_cnt inside {[16'h0049:16'h004c], [16'h00c6:16'h00ca]}
			: oe_cnt inside {[16'h02ba:16'h02bd], [16'h05da:16'h05de]});
	endproperty
	a_oe_len: assert property (p_oe_len) else $error("pulldown length off");
	property p_low_only;
		dq_out == 1'b0;
	endproperty
	a_low_only: assert property (p_low_only) else $error("line driven high");
	property p_fn_silent;
		$rose(dq_oe) && !$past(dq_in) |-> !$past(fn_active);
	endproperty
	a_fn_silent: assert property (p_fn_silent) else $error("reply in function phase");
	property p_od_keep;
		$fell(overdrive_flag) |-> low_cnt >= 16'(RESET_LONG_CYC - 2);
	endproperty
	a_od_keep: assert property (p_od_keep) else $error("overdrive left early");
	property p_resume_fn;
		$rose(resume_selected_flag) |-> ##[0:3] fn_active;
	endproperty
	a_resume_fn: assert property (p_resume_fn) else $error("resume flag without select");
	property p_rx_hold;
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("byte lost while stalled");
	property p_rx_fn;
		$rose(rx_valid) |-> $past(fn_active, 2);
	endproperty
	a_rx_fn: assert property (p_rx_fn) else $error("byte outside function phase");
	c_fn: cover property ($rose(fn_active));
	c_od: cover property ($rose(overdrive_flag));
	c_pop: cover property (rx_valid && rx_ready);
endmodule
bind swr_slot_rom swr_slot_rom_props #(
	.ROM_ID(ROM_ID), .RESET_LONG_CYC(RESET_LONG_CYC), .FIFO_DEPTH(FIFO_DEPTH)
) i_props (.core_clk(core_clk), .resetn(resetn), .dq_in(dq_in), .dq_out(dq_out),
	.dq_oe(dq_oe), .fn_active(fn_active), .overdrive_flag(overdrive_flag),
	.resume_selected_flag(resume_selected_flag), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_ready(rx_ready));

// File: verification/swr_host_model.sv
// Purpose: Bus controller model: slots, bytes, identifiers and resets
// Assumes: Pull-up on the line; pull high means we hold it low
// Notes:   fast selects overdrive figures, in core_clk cycles
`timescale 1ns/10ps
module swr_host_model (
	// Clock and speed
	input  wire logic core_clk,
	input  wire logic fast,
	// Shared line
	input  wire logic line,
	output logic      pull
);
	initial pull = 1'b0;
	// One slot; a read is a write-one slot sampled mid-window
	task automatic slot(input logic wbit, output logic rbit);
		int rel;
		int smp;
		int tot;
		rel = wbit ? 2 : (fast ? 120 : 770);
		smp = fast ? 40 : 300;
		tot = fast ? 140 : 800;
		rbit = 1'b1;
		pull <= 1'b1;
		for (int i = 1; i <= tot; i++) begin
			@(posedge core_clk);
			if (i == rel) begin
				pull <= 1'b0;
			end
			if (i == smp) begin
				rbit = line;
			end
		end
	endtask
	// Byte, low bit first
	task automatic send_byte(input logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++) slot(b[i], r);
	endtask
	// Identifier out, low bit first
	task automatic send_id(input logic [63:0] v);
		logic r;
		for (int i = 0; i < 64; i++) slot(v[i], r);
	endtask
	// Identifier in, low bit first
	task automatic read_id(output logic [63:0] v);
		for (int i = 0; i < 64; i++) slot(1'b1, v[i]);
	endtask
	// Reset pulse, then watch for presence
	task automatic bus_reset(input int low, output logic seen);
		seen = 1'b0;
		pull <= 1'b1;
		repeat (low) @(posedge core_clk);
		pull <= 1'b0;
		repeat (fast ? 300 : 2000) begin
			@(posedge core_clk);
			if (!line) seen = 1'b1;
		end
	endtask
endmodule

// File: verification/single_wire_slot_and_rom_layer_tb.sv
// Purpose: Self-checking bench for the slot and ROM layer
// Assumes: Shortened long reset of 1600 cycles; overdrive reset threshold 1200, pulsed at 1300
// Notes:   Heavy sequences run at overdrive speed to keep the run short
`timescale 1ns/10ps
module single_wire_slot_and_rom_layer_tb;
	localparam logic [63:0] TID = 64'h9c41_07e3_b258_d16a; // Arbitrary identifier
	logic       core_clk;
	logic       resetn;
	logic       rx_ready;
	logic       host_fast;
	logic       host_pull;
	logic       dq_out;
	logic       dq_oe;
	logic       fn_active;
	logic       od;
	logic       rsel;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       dq_line;
	int         errors;
	int         num_checks;
	// Wired-AND of both parties over the pull-up
	assign dq_line = !(host_pull || (dq_oe && !dq_out));
	always #20 core_clk = !core_clk;
	swr_slot_rom #(.ROM_ID(TID), .RESET_LONG_CYC(1600), .FIFO_DEPTH(4)) i_dut (
		.core_clk(core_clk), .resetn(resetn), .dq_in(dq_line), .dq_out(dq_out),
		.dq_oe(dq_oe), .fn_active(fn_active), .overdrive_flag(od),
		.resume_selected_flag(rsel), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready));
	swr_host_model i_host (.core_clk(core_clk), .fast(host_fast), .line(dq_line),
		.pull(host_pull));
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Reset pulse with presence expected
	task automatic rst(input int low, input logic [7:0] cmd);
		logic seen;
		i_host.bus_reset(low, seen);
		check(64'(seen), 64'h1);
		i_host.send_byte(cmd);
	endtask
	// Wait for a byte, stall, then take it
	task automatic pop_byte(input logic [7:0] exp);
		int n;
		n = 0;
		while (rx_valid !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 20) begin
			errors++;
			tally_and_finish();
		end
		repeat (3) @(posedge core_clk);
		check(64'(rx_data), 64'(exp));
		rx_ready <= 1'b1;
		@(posedge core_clk);
		rx_ready <= 1'b0;
		@(posedge core_clk);
	endtask
	// Overdrive skip, then overfill the byte buffer
	task automatic t_od_skip();
		rst(1700, swr_pkg::CMD_OD_SKIP);
		host_fast <= 1'b1;
		@(posedge core_clk);
		check(64'(od), 64'h1);
		check(64'(fn_active), 64'h1);
		for (int k = 0; k < 6; k++) i_host.send_byte(8'(k * 53 + 90));
		for (int k = 0; k < 5; k++) pop_byte(8'(k * 53 + 90));
		check(64'(rx_valid), 64'h0);
		$display("test od_skip done");
	endtask
	// Short reset keeps overdrive; identifier read
	task automatic t_read_id();
		logic [63:0] got;
		rst(1300, swr_pkg::CMD_READ_ID);
		check(64'(od), 64'h1);
		i_host.read_id(got);
		check(got, TID);
		$display("test read_id done");
	endtask
	// Full search pass, resume, then a dropped pass
	task automatic t_search();
		logic a;
		logic b;
		rst(1300, swr_pkg::CMD_SEARCH);
		for (int i = 0; i < 64; i++) begin
			i_host.slot(1'b1, a);
			i_host.slot(1'b1, b);
			check(64'({a, b}), 64'({TID[i], !TID[i]}));
			i_host.slot(TID[i], a);
		end
		check(64'({rsel, fn_active}), 64'h3);
		rst(1300, swr_pkg::CMD_RESUME);
		check(64'(fn_active), 64'h1);
		rst(1300, swr_pkg::CMD_SEARCH);
		i_host.slot(1'b1, a);
		i_host.slot(1'b1, b);
		i_host.slot(!TID[0], a);
		i_host.slot(1'b1, a);
		i_host.slot(1'b1, b);
		check(64'({a, b}), 64'h3);
		rst(1300, swr_pkg::CMD_RESUME);
		check(64'({rsel, fn_active}), 64'h0);
		$display("test search done");
	endtask
	// Failed match, stray code, then overdrive match
	task automatic t_match();
		rst(1300, swr_pkg::CMD_MATCH);
		i_host.send_id(TID ^ 64'h8000_0000_0000_0000);
		check(64'(fn_active), 64'h0);
		i_host.send_byte(8'h00);
		check(64'(rx_valid), 64'h0);
		rst(1300, 8'h00);
		check(64'(fn_active), 64'h0);
		rst(1300, swr_pkg::CMD_OD_MATCH);
		i_host.send_id(TID);
		check(64'({od, rsel, fn_active}), 64'h7);
		$display("test match done");
	endtask
	// Long reset back to standard speed, then skip
	task automatic t_long();
		host_fast <= 1'b0;
		@(posedge core_clk);
		rst(1700, swr_pkg::CMD_SKIP);
		check(64'({od, fn_active}), 64'h1);
		$display("test long_reset done");
	endtask
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		rx_ready = 1'b0;
		host_fast = 1'b0;
		errors = 0;
		num_checks = 0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_od_skip();
		t_read_id();
		t_search();
		t_match();
		t_long();
		tally_and_finish();
	end
endmodule
